// File: hdl/spindle_pkg.sv
/*
 package for the sensorless spindle speed control core: register map,
 field positions, reset values and timing counts.
 assumes a single 200 MHz clock and an AXI4-Lite master outside.
*/
package spindle_pkg;
    // register byte addresses
    localparam logic [3:0] ctrl_addr = 4'h0;
    localparam logic [3:0] status_addr = 4'h4;
    localparam logic [3:0] period_addr = 4'h8;
    localparam logic [3:0] code_addr = 4'hc;
    // ctrl field positions
    localparam int ctrl_brake_pos = 0;
    localparam int ctrl_reset_pos = 1;
    localparam int ctrl_step_pos = 2;
    localparam int ctrl_index_sel_pos = 3;
    localparam logic [3:0] ctrl_reset_value = 4'h0;
    // status field positions
    localparam int status_state_pos = 0;
    localparam int status_lock_pos = 3;
    localparam int status_slow_pos = 4;
    localparam int status_mode_pos = 5;
    // code register field positions
    localparam int code_integral_pos = 8;
    // timing: reference tick from the system clock
    localparam int clock_mhz = 200;
    localparam int reference_khz = 2000;
    localparam int reference_div = clock_mhz * 1000 / reference_khz;
    localparam int period_tick_div = 4;
    // period measurement
    localparam logic [15:0] period_nominal = 16'd8333;
    localparam logic [15:0] lock_window = 16'd15;
    localparam logic [15:0] slow_limit = 16'd250;
    // commutation timing ratios (numerator over 100 and over 7)
    localparam logic [7:0] delay_num = 8'd43;
    localparam logic [7:0] delay_den = 8'd100;
    localparam logic [7:0] blank_num = 8'd5;
    localparam logic [7:0] blank_den = 8'd7;
    localparam logic [5:0] prop_mid = 6'h20;

    typedef enum logic [1:0] {
        mode_sleep,
        mode_brake,
        mode_retract,
        mode_run
    } mode_type;

    typedef struct packed {
        logic high_a;
        logic high_b;
        logic high_c;
        logic low_a;
        logic low_b;
        logic low_c;
    } drive_type;

    typedef struct packed {
        logic [3:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [3:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_resp_type;
endpackage

// File: hdl/emf_timer.sv
/*
 adaptive commutation delay and noise blanking timer.
 assumes comparison events arrive as one-cycle pulses on reference ticks.
*/
`timescale 1ns/10ps
module emf_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic tick,
    // events
    input wire logic compare_event,
    output logic commutate
);
    import spindle_pkg::*;

    logic [15:0] interval;
    logic [15:0] last_interval;
    logic [15:0] delay_left;
    logic [15:0] blank_left;
    logic delay_armed;
    logic accepted;
    logic [23:0] delay_product;
    logic [23:0] blank_product;

    assign accepted = compare_event && blank_left == 16'h0000;
    assign delay_product = (24'(interval) * 24'(delay_num)) / 24'(delay_den);
    assign blank_product = (24'(interval) * 24'(blank_num)) / 24'(blank_den);

    // interval measured in reference ticks
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            interval <= 16'h0000;
            last_interval <= 16'h0000;
        end else if (accepted) begin
            last_interval <= interval;
            interval <= 16'h0000;
        end else if (tick && interval != 16'hffff) begin
            interval <= interval + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            delay_left <= 16'h0000;
            delay_armed <= 1'b0;
            commutate <= 1'b0;
        end else begin
            commutate <= 1'b0;
            if (accepted) begin
                delay_left <= delay_product[15:0];
                delay_armed <= 1'b1;
            end else if (delay_armed && delay_left == 16'h0000) begin
                delay_armed <= 1'b0;
                commutate <= 1'b1;
            end else if (tick && delay_armed) begin
                delay_left <= delay_left - 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            blank_left <= 16'h0000;
        end else if (accepted) begin
            blank_left <= blank_product[15:0];
        end else if (tick && blank_left != 16'h0000) begin
            blank_left <= blank_left - 16'h0001;
        end
    end
endmodule // emf_timer

// File: hdl/spindle_control.sv
/*
 sensorless spindle speed control core: commutation counter and driver
 decode, period measurement, proportional and integral codes, lock flag.
 assumes synchronous inputs on aclk and an AXI4-Lite master for registers.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
// Operation
// - commutate 0.43 of the previous comparison interval after each event.
// - ignore comparison events for 5/7 of the last interval.
// - load period counter with 8333 and count down between indexes.
// - proportional code is low five residue bits plus sign.
// - zero error gives mid-scale; short lower, long higher.
// - speed_locked high when residue is within 15 counts of zero.
// - add low eight residue bits to an eight-bit accumulator; the code subtracts them from the accumulator instead.
// - integral code is accumulator upper six bits.
// - large errors saturate both codes at the corrective extreme.
// - over 3% slow selects full-scale reference for control voltage.
// - brake and reset inputs select sleep, brake, retract or run.
// - reset low clears counters, registers and the accumulator.
// - each step_phase rising edge advances the commutation counter.
// - step_phase held high suppresses back-emf commutation.
// - index_source_select high takes index input, low drives phase_lsb.
// - six states decode into the listed high and low side pairs.
// - period counter ticks at one quarter of the reference rate.
`timescale 1ns/10ps
module spindle_control (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // register bus
    input wire spindle_pkg::axil_req_type axil_req,
    output spindle_pkg::axil_resp_type axil_resp,
    // motor side
    input wire logic compare_event,
    input wire logic index_pin_in,
    output logic index_pin_out,
    output logic index_pin_oe_n,
    output spindle_pkg::drive_type drive,
    output logic drive_float,
    output logic analog_on,
    // control outputs
    output logic [5:0] proportional_output,
    output logic [5:0] integral_output,
    output logic speed_locked,
    output logic full_scale_select
);
    import spindle_pkg::*;

    logic [3:0] ctrl;
    logic [2:0] step_sync;
    logic [2:0] index_sync;
    logic [7:0] ref_div;
    logic [1:0] quarter;
    logic ref_tick;
    logic period_tick;
    logic [2:0] phase;
    logic [2:0] next_phase;
    logic [15:0] period_count;
    logic [15:0] residue;
    logic [7:0] accumulator;
    logic [9:0] next_sum;
    logic commutate;
    logic int_index;
    logic index_event;
    logic step_edge;
    logic ext_sel;
    logic counters_clear;
    mode_type mode;
    drive_type next_drive;
    logic aw_done;
    logic w_done;
    logic [3:0] aw_hold;
    logic [31:0] w_hold;
    logic [3:0] w_strb;
    logic aw_ready;
    logic w_ready;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_ready;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;

    always_comb begin
        unique case ({ctrl[ctrl_brake_pos], ctrl[ctrl_reset_pos]})
            2'b00: mode = mode_sleep;
            2'b01: mode = mode_brake;
            2'b10: mode = mode_retract;
            2'b11: mode = mode_run;
        endcase
    end
    // counters cleared while reset bit low
    assign counters_clear = !ctrl[ctrl_reset_pos];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_sync <= 3'h0;
            index_sync <= 3'h0;
        end else if (clk_en) begin
            step_sync <= {step_sync[1:0], ctrl[ctrl_step_pos]};
            index_sync <= {index_sync[1:0], index_pin_in};
        end
    end
    assign step_edge = step_sync[1] && !step_sync[2];
    assign ext_sel = ctrl[ctrl_index_sel_pos];

    // reference tick and quarter-rate period tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_div <= 8'h00;
            quarter <= 2'h0;
        end else if (clk_en) begin
            if (ref_div == 8'(reference_div - 1)) begin
                ref_div <= 8'h00;
                quarter <= quarter + 2'h1;
            end else begin
                ref_div <= ref_div + 8'h01;
            end
        end
    end
    assign ref_tick = ref_div == 8'(reference_div - 1);
    assign period_tick = ref_tick && quarter == 2'(period_tick_div - 1);

    emf_timer timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(counters_clear),
        .tick(ref_tick && clk_en),
        .compare_event(compare_event && clk_en),
        .commutate(commutate)
    );

    always_comb begin
        next_phase = phase;
        if (step_edge || (commutate && !step_sync[1])) begin
            next_phase = (phase == 3'd5) ? 3'd0 : phase + 3'd1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || counters_clear) begin
            phase <= 3'd0;
            int_index <= 1'b0;
        end else if (clk_en) begin
            phase <= next_phase;
            int_index <= next_phase == 3'd0 && phase != 3'd0;
        end
    end
    assign index_event = ext_sel ? (index_sync[1] && !index_sync[2]) : int_index;

    always_comb begin
        next_drive = '0;
        unique case (phase)
            3'd0: next_drive = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            3'd1: next_drive = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            3'd2: next_drive = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
            3'd3: next_drive = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            3'd4: next_drive = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            3'd5: next_drive = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
            default: next_drive = '0;
        endcase
        if (mode == mode_sleep || mode == mode_brake) begin
            next_drive = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        end else if (mode == mode_retract) begin
            next_drive = '0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive <= '0;
            drive_float <= 1'b0;
            analog_on <= 1'b0;
            index_pin_out <= 1'b1;
            index_pin_oe_n <= 1'b0;
        end else if (clk_en) begin
            drive <= next_drive;
            drive_float <= mode == mode_retract;
            analog_on <= mode != mode_sleep;
            // index pin direction, phase_lsb high in even states
            index_pin_out <= !phase[0];
            index_pin_oe_n <= ext_sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || counters_clear) begin
            period_count <= period_nominal;
            residue <= 16'h0000;
        end else if (clk_en) begin
            if (index_event) begin
                residue <= period_count;
                period_count <= period_nominal;
            end else if (period_tick && period_count != 16'h8000) begin
                period_count <= period_count - 16'h0001;
            end
        end
    end

    assign next_sum = {2'b00, accumulator} - {{2{period_count[15]}}, period_count[7:0]};
    always_ff @(posedge aclk) begin
        if (!aresetn || counters_clear) begin
            accumulator <= 8'h80;
            proportional_output <= prop_mid;
            integral_output <= 6'h20;
            speed_locked <= 1'b0;
            full_scale_select <= 1'b0;
        end else if (clk_en && index_event) begin
            if ($signed(period_count) < -$signed({1'b0, slow_limit[14:0]})) begin
                accumulator <= 8'hff;
                proportional_output <= 6'h3f;
                integral_output <= 6'h3f;
            end else if ($signed(period_count) > $signed({1'b0, slow_limit[14:0]})) begin
                accumulator <= 8'h00;
                proportional_output <= 6'h00;
                integral_output <= 6'h00;
            end else begin
                if ($signed(period_count) > 16'sd31) begin
                    proportional_output <= 6'h00;
                end else if ($signed(period_count) < -16'sd31) begin
                    proportional_output <= 6'h3f;
                end else begin
                    proportional_output <= prop_mid - period_count[5:0];
                end
                if (next_sum[9]) begin
                    accumulator <= 8'h00;
                    integral_output <= 6'h00;
                end else if (next_sum[8]) begin
                    accumulator <= 8'hff;
                    integral_output <= 6'h3f;
                end else begin
                    accumulator <= next_sum[7:0];
                    integral_output <= next_sum[7:2];
                end
            end
            speed_locked <= $signed(period_count) <= $signed(lock_window)
                && $signed(period_count) >= -$signed(lock_window);
            full_scale_select <= $signed(period_count) < -$signed(slow_limit);
        end
    end

    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_done <= 1'b0;
            w_done <= 1'b0;
            aw_hold <= 4'h0;
            w_hold <= 32'h0;
            w_strb <= 4'h0;
            ctrl <= ctrl_reset_value;
            aw_ready <= 1'b0;
            w_ready <= 1'b0;
            b_valid <= 1'b0;
            b_resp <= 2'b00;
        end else if (clk_en) begin
            aw_ready <= 1'b0;
            w_ready <= 1'b0;
            if (axil_req.awvalid && !aw_done && !aw_ready && !b_valid) begin
                aw_ready <= 1'b1;
                aw_done <= 1'b1;
                aw_hold <= axil_req.awaddr;
            end
            if (axil_req.wvalid && !w_done && !w_ready && !b_valid) begin
                w_ready <= 1'b1;
                w_done <= 1'b1;
                w_hold <= axil_req.wdata;
                w_strb <= axil_req.wstrb;
            end
            if (aw_done && w_done && !b_valid) begin
                b_valid <= 1'b1;
                aw_done <= 1'b0;
                w_done <= 1'b0;
                if (aw_hold == ctrl_addr) begin
                    b_resp <= 2'b00;
                    if (w_strb[0]) begin
                        ctrl <= w_hold[3:0];
                    end
                end else begin
                    b_resp <= 2'b10;
                end
            end else if (b_valid && axil_req.bready) begin
                b_valid <= 1'b0;
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_ready <= 1'b0;
            r_valid <= 1'b0;
            r_data <= 32'h0;
            r_resp <= 2'b00;
        end else if (clk_en) begin
            ar_ready <= 1'b0;
            if (axil_req.arvalid && !ar_ready && !r_valid) begin
                ar_ready <= 1'b1;
                r_valid <= 1'b1;
                r_resp <= 2'b00;
                unique case (axil_req.araddr)
                    ctrl_addr: r_data <= {28'h0, ctrl};
                    status_addr: r_data <= {25'h0, mode,
                        full_scale_select, speed_locked, phase};
                    period_addr: r_data <= {16'h0, residue};
                    code_addr: r_data <= {18'h0, integral_output,
                        2'b00, proportional_output};
                    default: begin
                        r_data <= 32'h0;
                        r_resp <= 2'b10;
                    end
                endcase
            end else if (r_valid && axil_req.rready) begin
                r_valid <= 1'b0;
            end
        end
    end
    // one driver for the whole response struct
    assign axil_resp = {aw_ready, w_ready, b_resp, b_valid, ar_ready, r_data, r_resp, r_valid};
endmodule // spindle_control

// File: tb/spindle_asserts.sv
/*
 output checks for the spindle control core.
 assumes a bind onto spindle_control from the bench top.
*/
`timescale 1ns/10ps
module spindle_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched outputs
    input wire spindle_pkg::drive_type drive,
    input wire logic drive_float,
    input wire logic analog_on,
    input wire logic index_pin_out,
    input wire logic [5:0] proportional_output,
    input wire logic speed_locked,
    input wire logic full_scale_select
);
    import spindle_pkg::*;
    logic [5:0] d;
    assign d = drive;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    function automatic logic [5:0] succ(input logic [5:0] s);
        case (s)
            6'h22: return 6'h21;
            6'h21: return 6'h11;
            6'h11: return 6'h14;
            6'h14: return 6'h0c;
            6'h0c: return 6'h0a;
            default: return 6'h22;
        endcase
    endfunction
    sequence driven_s;
        d[5:3] != 3'h0 && !drive_float;
    endsequence
    sequence moved_s;
        driven_s ##1 driven_s ##0 d != $past(d);
    endsequence
    reset_clear_a:
        assert property (disable iff (1'b0) !aresetn |=> d == 6'h00 && !speed_locked
            && proportional_output == prop_mid) else $error("outputs not cleared by reset");
    legal_state_a:
        assert property (d[5:3] != 3'h0 |-> d inside {6'h22, 6'h21, 6'h11, 6'h14, 6'h0c, 6'h0a})
        else $error("illegal driver pair");
    state_order_a:
        assert property (moved_s |-> d == succ($past(d))) else $error("commutation skipped");
    even_lsb_a:
        assert property ($stable(d) && d[5:3] != 3'h0 |-> index_pin_out == (d inside {6'h22,
            6'h11, 6'h0c})) else $error("phase lsb does not match state");
    sleep_quiet_a:
        assert property (!analog_on |-> d[5:3] == 3'h0 && !drive_float)
        else $error("drivers active in sleep");
    float_analog_a:
        assert property (drive_float |-> analog_on) else $error("retract without analog");
    lock_clear_a:
        assert property (full_scale_select |-> !speed_locked) else $error("locked while slow");
    lock_prop_a:
        assert property (speed_locked && $stable(speed_locked) && $stable(proportional_output)
            |-> proportional_output inside {[6'h11:6'h2f]}) else $error("lock outside window");
    slow_prop_a:
        assert property (full_scale_select && $stable(full_scale_select)
            && $stable(proportional_output) |-> proportional_output == 6'h3f)
        else $error("slow code not saturated");
    cover property (moved_s);
endmodule // spindle_asserts

// File: tb/cpu_model.sv
/*
 companion processor model: AXI4-Lite master plus start-up helpers.
 assumes its tasks are called one at a time.
*/
`timescale 1ns/10ps
module cpu_model (
    // clock
    input wire logic aclk,
    // register bus
    output spindle_pkg::axil_req_type axil_req,
    input wire spindle_pkg::axil_resp_type axil_resp
);
    import spindle_pkg::*;
    logic [1:0] last_resp;
    initial axil_req = '0;
    task automatic write_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        axil_req.awaddr <= a;
        axil_req.awvalid <= 1'b1;
        axil_req.wdata <= v;
        axil_req.wstrb <= 4'hf;
        axil_req.wvalid <= 1'b1;
        axil_req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axil_resp.awready) axil_req.awvalid <= 1'b0;
            if (axil_resp.wready) axil_req.wvalid <= 1'b0;
        end while (!axil_resp.bvalid);
        last_resp = axil_resp.bresp;
        axil_req.bready <= 1'b0;
    endtask
    task automatic read_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge aclk);
        axil_req.araddr <= a;
        axil_req.arvalid <= 1'b1;
        axil_req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axil_resp.arready) axil_req.arvalid <= 1'b0;
        end while (!axil_resp.rvalid);
        v = axil_resp.rdata;
        last_resp = axil_resp.rresp;
        axil_req.rready <= 1'b0;
    endtask
    task automatic restart;
        write_reg(ctrl_addr, 32'h1);
        write_reg(ctrl_addr, 32'h3);
    endtask
    task automatic step(input logic [31:0] base);
        write_reg(ctrl_addr, base | 32'h4);
        write_reg(ctrl_addr, base);
    endtask
endmodule // cpu_model

// File: tb/sensorless_spindle_speed_control_bench.sv
/*
 self-checking bench for the spindle control core.
 assumes the processor model owns the register bus, the bench the motor side.
*/
`timescale 1ns/10ps
module sensorless_spindle_speed_control_bench;
    import spindle_pkg::*;
    localparam logic [5:0] state_drive [6] = '{6'h22, 6'h21, 6'h11, 6'h14, 6'h0c, 6'h0a};
    logic aclk, aresetn, clk_en, compare_event, index_pin_in, index_pin_out, index_pin_oe_n;
    logic drive_float, analog_on, speed_locked, full_scale_select;
    logic [5:0] proportional_output, integral_output, last_drive;
    logic [31:0] rd;
    axil_req_type axil_req;
    axil_resp_type axil_resp;
    drive_type drive;
    int mismatches, samples_checked, cycles, commutations;
    spindle_control dut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .axil_req(axil_req), .axil_resp(axil_resp),
        .compare_event(compare_event), .index_pin_in(index_pin_in),
        .index_pin_out(index_pin_out), .index_pin_oe_n(index_pin_oe_n),
        .drive(drive), .drive_float(drive_float), .analog_on(analog_on),
        .proportional_output(proportional_output), .integral_output(integral_output),
        .speed_locked(speed_locked), .full_scale_select(full_scale_select)
    );
    cpu_model cpu (.aclk(aclk), .axil_req(axil_req), .axil_resp(axil_resp));
    // fast clock from which the 2 MHz reference is divided
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic finish_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] want, input logic [31:0] seen);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, want, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic emf_pulse;
        @(posedge aclk);
        compare_event <= 1'b1;
        @(posedge aclk);
        compare_event <= 1'b0;
    endtask
    task automatic index_pulse;
        @(posedge aclk);
        index_pin_in <= 1'b1;
        cyc(10);
        index_pin_in <= 1'b0;
    endtask
    // counts commutations and cuts a hang short
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        last_drive <= drive;
        if (drive[5:3] != 3'h0 && last_drive[5:3] != 3'h0 && drive != last_drive) begin
            commutations <= commutations + 1;
        end
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end
    task automatic test_reset;
        check("drive", 32'h0, 32'(drive));
        check("phase_lsb", 32'h1, 32'(index_pin_out));
        check("index_oe_n", 32'h0, 32'(index_pin_oe_n));
        check("proportional", 32'(prop_mid), 32'(proportional_output));
        check("integral", 32'h20, 32'(integral_output));
        check("locked", 32'h0, 32'(speed_locked));
        cpu.read_reg(ctrl_addr, rd);
        check("ctrl", 32'(ctrl_reset_value), rd);
    endtask
    task automatic test_modes;
        for (int m = 0; m < 4; m++) begin
            cpu.write_reg(ctrl_addr, 32'(m));
            cyc(4);
            cpu.read_reg(status_addr, rd);
            check("mode", 32'({m[0], m[1]}), 32'(rd[6:5]));
            check("analog_on", 32'(m != 0), 32'(analog_on));
            check("drive_float", 32'(m == 1), 32'(drive_float));
        end
    endtask
    task automatic test_steps;
        cpu.restart();
        cyc(4);
        for (int i = 0; i < 7; i++) begin
            if (i > 0) begin
                cpu.step(32'h3);
                cyc(4);
            end
            check("drive", 32'(state_drive[i % 6]), 32'(drive));
            check("phase_lsb", 32'(i % 2 == 0), 32'(index_pin_out));
            cpu.read_reg(status_addr, rd);
            check("phase", 32'(i % 6), 32'(rd[2:0]));
        end
        cpu.write_reg(status_addr, 32'hff);
        check("bresp", 32'h2, 32'(cpu.last_resp));
        cpu.read_reg(ctrl_addr, rd);
        check("ctrl", 32'h3, rd);
    endtask
    task automatic test_emf;
        int n;
        cpu.write_reg(ctrl_addr, 32'h0);
        cpu.write_reg(ctrl_addr, 32'h3);
        emf_pulse();
        cyc(1998);
        emf_pulse();
        cyc(1998);
        n = commutations;
        emf_pulse();
        cyc(500);
        emf_pulse();
        cyc(200);
        check("early_commutations", n, commutations);
        cyc(400);
        check("delayed_commutations", n + 1, commutations);
        cyc(900);
        check("blanked_commutations", n + 1, commutations);
    endtask
    task automatic test_hold;
        int n;
        cpu.write_reg(ctrl_addr, 32'h7);
        cyc(10);
        n = commutations;
        emf_pulse();
        cyc(1998);
        emf_pulse();
        cyc(1998);
        emf_pulse();
        cyc(1500);
        check("held_commutations", n, commutations);
    endtask
    task automatic test_index;
        logic [15:0] want;
        want = period_nominal - 16'(8000 / (reference_div * period_tick_div));
        cpu.write_reg(ctrl_addr, 32'hb);
        cyc(4);
        check("index_oe_n", 32'h1, 32'(index_pin_oe_n));
        index_pulse();
        cyc(7989);
        index_pulse();
        cyc(30);
        cpu.read_reg(period_addr, rd);
        check("residue", 32'h1, 32'(rd[15:0] + 16'd2 - want <= 16'd4));
        check("proportional", 32'h0, 32'(proportional_output));
        check("integral", 32'h0, 32'(integral_output));
        check("locked", 32'h0, 32'(speed_locked));
        check("full_scale", 32'h0, 32'(full_scale_select));
        cpu.read_reg(code_addr, rd);
        check("code", 32'h0, 32'(rd[13:0]));
    endtask
    initial begin
        aresetn = 1'b0;
        clk_en = 1'b1;
        compare_event = 1'b0;
        index_pin_in = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        commutations = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_modes();
        test_steps();
        test_emf();
        test_hold();
        test_index();
        finish_test();
    end
endmodule // sensorless_spindle_speed_control_bench
bind spindle_control spindle_asserts checker_i (
    .aclk(aclk), .aresetn(aresetn), .drive(drive), .drive_float(drive_float),
    .analog_on(analog_on), .index_pin_out(index_pin_out),
    .proportional_output(proportional_output), .speed_locked(speed_locked),
    .full_scale_select(full_scale_select)
);
